/* rtl/dpc_pkg.sv */
// Shared constants and types for the sample-clock PLL setup block.
package dpc_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam int unsigned ADDR_W           = 15;
   localparam logic [14:0] OFS_PLL_CTRL     = 15'h0083;
   localparam logic [14:0] OFS_STATUS       = 15'h0084;
   localparam logic [14:0] OFS_LOOP_COUNT   = 15'h0085;
   localparam logic [14:0] OFS_LF_A         = 15'h0087;
   localparam logic [14:0] OFS_LF_B         = 15'h0088;
   localparam logic [14:0] OFS_LF_C         = 15'h0089;
   localparam logic [14:0] OFS_CP_CURRENT   = 15'h008a;
   localparam logic [14:0] OFS_VCO_DIV      = 15'h008b;
   localparam logic [14:0] OFS_REF_DIV      = 15'h008c;
   localparam logic [14:0] OFS_CP_TRIM      = 15'h008d;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned CTRL_SRC_BIT     = 0;
   localparam int unsigned CTRL_ENABLE_BIT  = 4;
   localparam int unsigned STAT_LOCK_BIT    = 1;
   localparam int unsigned STAT_CAL_BIT     = 5;

   // ****************************************
   // Reset values and legal ranges
   // ****************************************
   localparam logic [7:0] RST_CTRL          = 8'h00;
   localparam logic [7:0] RST_LOOP_COUNT    = 8'h08;
   localparam logic [7:0] RST_LF            = 8'h00;
   localparam logic [3:0] RST_LF_C          = 4'h0;
   localparam logic [5:0] RST_CP_CURRENT    = 6'h00;
   localparam logic [1:0] RST_VCO_CODE      = 2'h2;
   localparam logic [2:0] RST_REF_CODE      = 3'h0;
   localparam logic [7:0] RST_CP_TRIM       = 8'h00;
   localparam logic [7:0] LOOP_COUNT_MIN    = 8'h06;
   localparam logic [7:0] LOOP_COUNT_MAX    = 8'h7f;
   localparam logic [2:0] REF_CODE_MAX      = 3'h4;
   localparam logic [1:0] VCO_CODE_MIN      = 2'h1;

   // ****************************************
   // Serial port framing
   // ****************************************
   localparam logic [4:0] SPI_INSTR_BITS    = 5'h10;
   localparam logic [4:0] SPI_FRAME_BITS    = 5'h18;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_RUN,
      CAL_DONE
   } dpc_cal_state_type;

endpackage : dpc_pkg

/* rtl/dpc_spi_slave.sv */
// Serial control port slave: 16-bit instruction then one data byte, mode 0.
`timescale 1ns/1ps
`default_nettype none
module dpc_spi_slave (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        cs_n_in,
   input  wire logic        sclk_in,
   input  wire logic        sdi_in,
   input  wire logic [7:0]  rd_data_in,
   output logic             sdo_out,
   output logic             sdo_oe_out,
   output logic [14:0]      addr_out,
   output logic             wr_strobe_out,
   output logic [7:0]       wr_data_out
);

   typedef struct packed {
      logic [2:0]  cs_sync;
      logic [2:0]  sclk_sync;
      logic [2:0]  sdi_sync;
      logic        cs_n;
      logic        sclk;
      logic        sdi;
      logic [4:0]  cnt;
      logic [15:0] instr;
      logic [7:0]  data;
      logic [7:0]  out_shift;
      logic        sdo;
      logic        sdo_oe;
      logic        wr_strobe;
      logic [14:0] addr;
   } dpc_spi_state_type;

   dpc_spi_state_type q;
   dpc_spi_state_type next_q;

   // ****************************************
   // Next state
   // ****************************************
   // The pins are oversampled, so the serial clock must stay well below a
   // quarter of the system clock for every edge to be seen.
   always_comb begin
      next_q = q;
      next_q.wr_strobe = 1'b0;
      next_q.cs_sync   = {q.cs_sync[1:0], cs_n_in};
      next_q.sclk_sync = {q.sclk_sync[1:0], sclk_in};
      next_q.sdi_sync  = {q.sdi_sync[1:0], sdi_in};
      if (q.cs_sync[1] == q.cs_sync[2]) begin
         next_q.cs_n = q.cs_sync[2];
      end
      if (q.sclk_sync[1] == q.sclk_sync[2]) begin
         next_q.sclk = q.sclk_sync[2];
      end
      if (q.sdi_sync[1] == q.sdi_sync[2]) begin
         next_q.sdi = q.sdi_sync[2];
      end
      if (q.cs_n) begin
         next_q.cnt    = 5'h00;
         next_q.sdo_oe = 1'b0;
      end else if (next_q.sclk && !q.sclk) begin
         if (q.cnt < dpc_pkg::SPI_INSTR_BITS) begin
            next_q.instr = {q.instr[14:0], q.sdi};
            if (q.cnt == dpc_pkg::SPI_INSTR_BITS - 5'h01) begin
               next_q.addr = {q.instr[13:0], q.sdi};
            end
         end else if (q.cnt < dpc_pkg::SPI_FRAME_BITS) begin
            next_q.data = {q.data[6:0], q.sdi};
            if (q.cnt == dpc_pkg::SPI_FRAME_BITS - 5'h01 && !q.instr[15]) begin
               next_q.wr_strobe = 1'b1;
            end
         end
         if (q.cnt != dpc_pkg::SPI_FRAME_BITS) begin
            next_q.cnt = q.cnt + 5'h01;
         end
      end else if (!next_q.sclk && q.sclk && q.instr[15]) begin
         if (q.cnt == dpc_pkg::SPI_INSTR_BITS) begin
            next_q.out_shift = rd_data_in;
            next_q.sdo       = rd_data_in[7];
            next_q.sdo_oe    = 1'b1;
         end else if (q.cnt < dpc_pkg::SPI_FRAME_BITS) begin
            next_q.out_shift = {q.out_shift[6:0], 1'b0};
            next_q.sdo       = q.out_shift[6];
         end else begin
            next_q.sdo_oe = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '{cs_sync: 3'h7, sclk_sync: 3'h0, sdi_sync: 3'h0, cs_n: 1'b1,
                sclk: 1'b0, sdi: 1'b0, cnt: 5'h00, instr: 16'h0000, data: 8'h00,
                out_shift: 8'h00, sdo: 1'b0, sdo_oe: 1'b0, wr_strobe: 1'b0,
                addr: 15'h0000};
      end else begin
         q <= next_q;
      end
   end

   assign sdo_out       = q.sdo;
   assign sdo_oe_out    = q.sdo_oe;
   assign addr_out      = q.addr;
   assign wr_strobe_out = q.wr_strobe;
   assign wr_data_out   = q.data;

endmodule : dpc_spi_slave
`default_nettype wire

/* rtl/dpc_clock_setup.sv */
// Sample-clock PLL configuration registers, calibration control and lock report.
//
// Behaviour
// - Sample clock comes from the clock input directly or from the PLL.
// - Reference divider code 0..4 selects ratio 1, 2, 4, 8, 16.
// - Loop divide count held at 0x85 accepts only values 6 through 127.
// - VCO divider code 1, 2, 3 selects ratio 4, 8, 16.
// - Six-bit charge pump current code held at 0x8a bits 5:0.
// - First enable calibrates charge pump, then sets status bit 5.
// - Five four-bit loop filter codes held at 0x87 through 0x89.
// - Lock is reported on status bit 1.
`timescale 1ns/1ps
`default_nettype none
module dpc_clock_setup (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        spi_cs_n_in,
   input  wire logic        spi_sclk_in,
   input  wire logic        spi_sdi_in,
   output logic             spi_sdo_out,
   output logic             spi_sdo_oe_out,
   input  wire logic        pll_lock_in,
   input  wire logic        cal_done_in,
   output logic             pll_enable_out,
   output logic             sample_clock_from_pll_out,
   output logic             cal_start_out,
   output logic             cal_complete_out,
   output logic             pll_locked_out,
   output logic [2:0]       ref_divider_code_out,
   output logic [5:0]       ref_divide_ratio_out,
   output logic [1:0]       vco_divider_code_out,
   output logic [4:0]       vco_divide_ratio_out,
   output logic [7:0]       loop_divide_count_out,
   output logic [5:0]       charge_pump_current_out,
   output logic [3:0]       loop_filter_code0_out,
   output logic [3:0]       loop_filter_code1_out,
   output logic [3:0]       loop_filter_code2_out,
   output logic [3:0]       loop_filter_code3_out,
   output logic [3:0]       loop_filter_code4_out,
   output logic [7:0]       charge_pump_trim_out
);

   typedef struct packed {
      logic [7:0]                 ctrl;
      logic [7:0]                 loop_count;
      logic [7:0]                 lf_a;
      logic [7:0]                 lf_b;
      logic [3:0]                 lf_c;
      logic [5:0]                 cp_current;
      logic [1:0]                 vco_code;
      logic [4:0]                 vco_ratio;
      logic [2:0]                 ref_code;
      logic [5:0]                 ref_ratio;
      logic [7:0]                 cp_trim;
      logic [2:0]                 lock_sync;
      logic                       lock_stable;
      logic [2:0]                 done_sync;
      logic                       done_stable;
      logic                       en_prev;
      dpc_pkg::dpc_cal_state_type cal_state;
      logic                       cal_start;
      logic                       cal_complete;
      logic                       locked;
      logic                       from_pll;
   } dpc_top_state_type;

   dpc_top_state_type q;
   dpc_top_state_type next_q;

   logic [14:0] bus_addr;
   logic        bus_wr;
   logic [7:0]  bus_wr_data;
   logic [7:0]  bus_rd_data;

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic [5:0] ref_ratio_of(input logic [2:0] code);
      ref_ratio_of = 6'(6'h01 << code);
   endfunction : ref_ratio_of

   function automatic logic [4:0] vco_ratio_of(input logic [1:0] code);
      vco_ratio_of = 5'(5'h02 << code);
   endfunction : vco_ratio_of

   // ****************************************
   // Serial control port
   // ****************************************
   dpc_spi_slave u_spi (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .cs_n_in       (spi_cs_n_in),
      .sclk_in       (spi_sclk_in),
      .sdi_in        (spi_sdi_in),
      .rd_data_in    (bus_rd_data),
      .sdo_out       (spi_sdo_out),
      .sdo_oe_out    (spi_sdo_oe_out),
      .addr_out      (bus_addr),
      .wr_strobe_out (bus_wr),
      .wr_data_out   (bus_wr_data)
   );

   // ****************************************
   // Register read-back
   // ****************************************
   // Unmapped addresses and reserved bits read as zero, except that the control register at 0x83 reads back all eight bits as written.
   always_comb begin
      unique case (bus_addr)
         dpc_pkg::OFS_PLL_CTRL:   bus_rd_data = q.ctrl;
         dpc_pkg::OFS_STATUS: begin
            bus_rd_data = 8'h00;
            bus_rd_data[dpc_pkg::STAT_CAL_BIT]  = q.cal_complete;
            bus_rd_data[dpc_pkg::STAT_LOCK_BIT] = q.locked;
         end
         dpc_pkg::OFS_LOOP_COUNT: bus_rd_data = q.loop_count;
         dpc_pkg::OFS_LF_A:       bus_rd_data = q.lf_a;
         dpc_pkg::OFS_LF_B:       bus_rd_data = q.lf_b;
         dpc_pkg::OFS_LF_C:       bus_rd_data = {4'h0, q.lf_c};
         dpc_pkg::OFS_CP_CURRENT: bus_rd_data = {2'h0, q.cp_current};
         dpc_pkg::OFS_VCO_DIV:    bus_rd_data = {6'h00, q.vco_code};
         dpc_pkg::OFS_REF_DIV:    bus_rd_data = {5'h00, q.ref_code};
         dpc_pkg::OFS_CP_TRIM:    bus_rd_data = q.cp_trim;
         default:                 bus_rd_data = 8'h00;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_q = q;
      if (bus_wr) begin
         unique case (bus_addr)
            dpc_pkg::OFS_PLL_CTRL: next_q.ctrl = bus_wr_data;
            dpc_pkg::OFS_LOOP_COUNT: begin
               // Out-of-range counts would leave the loop divider undefined, so
               // such a write keeps the previous count.
               if (bus_wr_data >= dpc_pkg::LOOP_COUNT_MIN &&
                   bus_wr_data <= dpc_pkg::LOOP_COUNT_MAX) begin
                  next_q.loop_count = bus_wr_data;
               end
            end
            dpc_pkg::OFS_LF_A:       next_q.lf_a = bus_wr_data;
            dpc_pkg::OFS_LF_B:       next_q.lf_b = bus_wr_data;
            dpc_pkg::OFS_LF_C:       next_q.lf_c = bus_wr_data[3:0];
            dpc_pkg::OFS_CP_CURRENT: next_q.cp_current = bus_wr_data[5:0];
            dpc_pkg::OFS_VCO_DIV: begin
               if (bus_wr_data[1:0] >= dpc_pkg::VCO_CODE_MIN) begin
                  next_q.vco_code = bus_wr_data[1:0];
               end
            end
            dpc_pkg::OFS_REF_DIV: begin
               if (bus_wr_data[2:0] <= dpc_pkg::REF_CODE_MAX) begin
                  next_q.ref_code = bus_wr_data[2:0];
               end
            end
            dpc_pkg::OFS_CP_TRIM:    next_q.cp_trim = bus_wr_data;
            default: begin
            end
         endcase
      end
      next_q.ref_ratio = ref_ratio_of(next_q.ref_code);
      next_q.vco_ratio = vco_ratio_of(next_q.vco_code);

      // Analog status lines are asynchronous; a change counts once the second
      // and third stages agree.
      next_q.lock_sync = {q.lock_sync[1:0], pll_lock_in};
      next_q.done_sync = {q.done_sync[1:0], cal_done_in};
      if (q.lock_sync[1] == q.lock_sync[2]) begin
         next_q.lock_stable = q.lock_sync[2];
      end
      if (q.done_sync[1] == q.done_sync[2]) begin
         next_q.done_stable = q.done_sync[2];
      end

      next_q.en_prev = q.ctrl[dpc_pkg::CTRL_ENABLE_BIT];
      unique case (q.cal_state)
         dpc_pkg::CAL_IDLE: begin
            // Calibration uses whatever codes are loaded at the enable edge.
            if (q.ctrl[dpc_pkg::CTRL_ENABLE_BIT] && !q.en_prev) begin
               next_q.cal_state = dpc_pkg::CAL_RUN;
               next_q.cal_start = 1'b1;
            end
         end
         dpc_pkg::CAL_RUN: begin
            if (!q.ctrl[dpc_pkg::CTRL_ENABLE_BIT]) begin
               // An aborted run leaves the pump uncalibrated for the next enable.
               next_q.cal_state = dpc_pkg::CAL_IDLE;
               next_q.cal_start = 1'b0;
            end else if (q.done_stable) begin
               next_q.cal_state    = dpc_pkg::CAL_DONE;
               next_q.cal_start    = 1'b0;
               next_q.cal_complete = 1'b1;
            end
         end
         dpc_pkg::CAL_DONE: begin
            next_q.cal_complete = 1'b1;
         end
         default: begin
            next_q.cal_state = dpc_pkg::CAL_IDLE;
            next_q.cal_start = 1'b0;
         end
      endcase

      next_q.locked   = q.lock_stable && q.ctrl[dpc_pkg::CTRL_ENABLE_BIT];
      next_q.from_pll = q.ctrl[dpc_pkg::CTRL_SRC_BIT] &&
                        q.ctrl[dpc_pkg::CTRL_ENABLE_BIT];
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '{ctrl: dpc_pkg::RST_CTRL, loop_count: dpc_pkg::RST_LOOP_COUNT,
                lf_a: dpc_pkg::RST_LF, lf_b: dpc_pkg::RST_LF, lf_c: dpc_pkg::RST_LF_C,
                cp_current: dpc_pkg::RST_CP_CURRENT, vco_code: dpc_pkg::RST_VCO_CODE,
                vco_ratio: 5'h08, ref_code: dpc_pkg::RST_REF_CODE, ref_ratio: 6'h01,
                cp_trim: dpc_pkg::RST_CP_TRIM, lock_sync: 3'h0, lock_stable: 1'b0,
                done_sync: 3'h0, done_stable: 1'b0, en_prev: 1'b0,
                cal_state: dpc_pkg::CAL_IDLE, cal_start: 1'b0, cal_complete: 1'b0,
                locked: 1'b0, from_pll: 1'b0};
      end else begin
         q <= next_q;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign pll_enable_out            = q.ctrl[dpc_pkg::CTRL_ENABLE_BIT];
   assign sample_clock_from_pll_out = q.from_pll;
   assign cal_start_out             = q.cal_start;
   assign cal_complete_out          = q.cal_complete;
   assign pll_locked_out            = q.locked;
   assign ref_divider_code_out      = q.ref_code;
   assign ref_divide_ratio_out      = q.ref_ratio;
   assign vco_divider_code_out      = q.vco_code;
   assign vco_divide_ratio_out      = q.vco_ratio;
   assign loop_divide_count_out     = q.loop_count;
   assign charge_pump_current_out   = q.cp_current;
   assign loop_filter_code0_out     = q.lf_a[3:0];
   assign loop_filter_code1_out     = q.lf_a[7:4];
   assign loop_filter_code2_out     = q.lf_b[3:0];
   assign loop_filter_code3_out     = q.lf_b[7:4];
   assign loop_filter_code4_out     = q.lf_c;
   assign charge_pump_trim_out      = q.cp_trim;

endmodule : dpc_clock_setup
`default_nettype wire

/* verif/dpc_properties.sv */
// Concurrent checks on the ports of the sample-clock PLL setup block.
`timescale 1ns/1ps
`default_nettype none
module dpc_props_chk (
   input wire logic       clk_sys_in,
   input wire logic       rst_in,
   input wire logic       pll_lock_in,
   input wire logic       cal_done_in,
   input wire logic       pll_enable_out,
   input wire logic       sample_clock_from_pll_out,
   input wire logic       cal_start_out,
   input wire logic       cal_complete_out,
   input wire logic       pll_locked_out,
   input wire logic [2:0] ref_divider_code_out,
   input wire logic [5:0] ref_divide_ratio_out,
   input wire logic [1:0] vco_divider_code_out,
   input wire logic [4:0] vco_divide_ratio_out,
   input wire logic [7:0] loop_divide_count_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   chk_ref_ratio_map: assert property (ref_divide_ratio_out == (6'h01 << ref_divider_code_out))
      else $error("reference divide ratio does not follow its code");
   chk_ref_code_legal: assert property (ref_divider_code_out <= 3'h4)
      else $error("reserved reference divider code taken");
   chk_vco_ratio_map: assert property (vco_divider_code_out != 2'h0
      && vco_divide_ratio_out == (5'h02 << vco_divider_code_out))
      else $error("vco divide ratio does not follow its code");
   chk_loop_count_range: assert property (loop_divide_count_out >= 8'h06
      && loop_divide_count_out <= 8'h7f)
      else $error("loop divide count out of range");
   chk_cal_launch: assert property ($rose(pll_enable_out) && !cal_complete_out
      |-> ##[0:3] cal_start_out)
      else $error("first enable did not start calibration");
   chk_cal_finish: assert property (cal_start_out && cal_done_in ##1
      (pll_enable_out && cal_done_in) [*6] |-> cal_complete_out && !cal_start_out)
      else $error("calibration end not reported");
   chk_cal_sticky: assert property (cal_complete_out |-> !cal_start_out ##1 cal_complete_out)
      else $error("calibration flag dropped or calibration rerun");
   chk_lock_report: assert property ((pll_lock_in && pll_enable_out) [*8] |-> pll_locked_out)
      else $error("lock not reported");
   chk_lock_gated: assert property (!pll_enable_out && !$past(pll_enable_out) |-> !pll_locked_out)
      else $error("lock reported while pll disabled");
   chk_clock_source: assert property (sample_clock_from_pll_out
      |-> pll_enable_out || $past(pll_enable_out))
      else $error("sample clock taken from a disabled pll");
endmodule : dpc_props_chk

bind dpc_clock_setup dpc_props_chk dpc_props_chk_inst (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .pll_lock_in(pll_lock_in),
   .cal_done_in(cal_done_in), .pll_enable_out(pll_enable_out),
   .sample_clock_from_pll_out(sample_clock_from_pll_out), .cal_start_out(cal_start_out),
   .cal_complete_out(cal_complete_out), .pll_locked_out(pll_locked_out),
   .ref_divider_code_out(ref_divider_code_out), .ref_divide_ratio_out(ref_divide_ratio_out),
   .vco_divider_code_out(vco_divider_code_out), .vco_divide_ratio_out(vco_divide_ratio_out),
   .loop_divide_count_out(loop_divide_count_out));
`default_nettype wire

/* verif/dpc_pll_model.sv */
// Behavioural stand-in for the analog PLL core: calibration engine and lock detector.
`timescale 1ns/1ps
`default_nettype none
module dpc_pll_model #(
   parameter int CAL_DLY  = 40,
   parameter int LOCK_DLY = 80
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   input  wire logic pll_enable_in,
   input  wire logic cal_start_in,
   output logic      cal_done_out,
   output logic      pll_lock_out
);
   int cal_cnt;
   int lock_cnt;
   // Done stays up while enabled, as the real core does, so a slow sync still sees it.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cal_cnt      <= 0;
         lock_cnt     <= 0;
         cal_done_out <= 1'b0;
         pll_lock_out <= 1'b0;
      end else begin
         cal_cnt <= cal_start_in ? cal_cnt + 1 : 0;
         if (!pll_enable_in) cal_done_out <= 1'b0;
         else if (cal_start_in && cal_cnt >= CAL_DLY) cal_done_out <= 1'b1;
         if (!pll_enable_in) lock_cnt <= 0;
         else if (lock_cnt < LOCK_DLY) lock_cnt <= lock_cnt + 1;
         pll_lock_out <= pll_enable_in && lock_cnt >= LOCK_DLY;
      end
   end
endmodule : dpc_pll_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the sample-clock PLL setup block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       clk_sys_in, rst_in, cs_n, sclk, sdi, sdo, sdo_oe, lock, done;
   logic       en, src, cal_start, cal_cmp, locked;
   logic [2:0] ref_code;
   logic [5:0] ref_ratio, cp;
   logic [1:0] vco_code;
   logic [4:0] vco_ratio;
   logic [7:0] loop_cnt, trim;
   logic [3:0] lf0, lf1, lf2, lf3, lf4;
   int         err_total, n_checks;

   dpc_clock_setup dpc_clock_setup_inst (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
      .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .pll_lock_in(lock),
      .cal_done_in(done), .pll_enable_out(en), .sample_clock_from_pll_out(src),
      .cal_start_out(cal_start), .cal_complete_out(cal_cmp), .pll_locked_out(locked),
      .ref_divider_code_out(ref_code), .ref_divide_ratio_out(ref_ratio),
      .vco_divider_code_out(vco_code), .vco_divide_ratio_out(vco_ratio),
      .loop_divide_count_out(loop_cnt), .charge_pump_current_out(cp),
      .loop_filter_code0_out(lf0), .loop_filter_code1_out(lf1), .loop_filter_code2_out(lf2),
      .loop_filter_code3_out(lf3), .loop_filter_code4_out(lf4), .charge_pump_trim_out(trim));

   dpc_pll_model dpc_pll_model_inst (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .pll_enable_in(en),
      .cal_start_in(cal_start), .cal_done_out(done), .pll_lock_out(lock));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic wclk(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : wclk

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Phases of six clocks keep clear of the three-flop pin synchronisers.
   task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      output logic [7:0] rv);
      logic [23:0] f;
      f = {rd, a, wd};
      rv = 8'h00;
      cs_n <= 1'b0;
      wclk(6);
      for (int i = 23; i >= 0; i--) begin
         sdi <= f[i];
         wclk(6);
         if (rd && i < 8) begin
            rv[i] = sdo;
            chk("sdo_oe", 8'h01, {7'h00, sdo_oe});
         end
         sclk <= 1'b1;
         wclk(6);
         sclk <= 1'b0;
      end
      wclk(6);
      cs_n <= 1'b1;
      wclk(10);
      if (rd) begin
         chk("sdo_oe_off", 8'h00, {7'h00, sdo_oe});
      end
   endtask : spi

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] unused;
      spi(1'b0, a, d, unused);
   endtask : wr

   task automatic rd(input logic [14:0] a, output logic [7:0] d);
      spi(1'b1, a, 8'h00, d);
   endtask : rd

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk("ref_ratio", 8'h01, {2'h0, ref_ratio});
      chk("vco_code", 8'h02, {6'h00, vco_code});
      chk("loop_cnt", 8'h08, loop_cnt);
      chk("cal_cmp", 8'h00, {7'h00, cal_cmp});
   endtask : t_reset

   task automatic t_ref_codes();
      for (int c = 0; c < 8; c++) begin
         wr(dpc_pkg::OFS_REF_DIV, 8'(c));
         chk("ref_code", (c < 5) ? 8'(c) : 8'h04, {5'h00, ref_code});
         chk("ref_ratio", (c < 5) ? 8'h01 << c : 8'h10, {2'h0, ref_ratio});
      end
   endtask : t_ref_codes

   task automatic t_vco_codes();
      for (int c = 1; c < 5; c++) begin
         wr(dpc_pkg::OFS_VCO_DIV, 8'(c & 3));
         chk("vco_code", 8'h03 & 8'(c < 4 ? c : 3), {6'h00, vco_code});
         chk("vco_ratio", 8'h02 << (c < 4 ? c : 3), {3'h0, vco_ratio});
      end
   endtask : t_vco_codes

   task automatic t_loop_count();
      logic [7:0] v [5] = '{8'h06, 8'h7f, 8'h05, 8'h80, 8'hff};
      logic [7:0] r;
      for (int i = 0; i < 5; i++) begin
         wr(dpc_pkg::OFS_LOOP_COUNT, v[i]);
         chk("loop_cnt", (i == 0) ? 8'h06 : 8'h7f, loop_cnt);
      end
      rd(dpc_pkg::OFS_LOOP_COUNT, r);
      chk("loop_cnt_rd", 8'h7f, r);
   endtask : t_loop_count

   task automatic t_fixed_writes();
      logic [7:0] r;
      wr(dpc_pkg::OFS_CP_CURRENT, 8'hff);
      chk("cp_full", 8'h3f, {2'h0, cp});
      wr(dpc_pkg::OFS_LF_A, 8'h62);
      wr(dpc_pkg::OFS_LF_B, 8'hc9);
      wr(dpc_pkg::OFS_LF_C, 8'h0e);
      wr(dpc_pkg::OFS_CP_CURRENT, 8'h12);
      wr(dpc_pkg::OFS_CP_TRIM, 8'h7b);
      chk("lf_a", 8'h62, {lf1, lf0});
      chk("lf_b", 8'hc9, {lf3, lf2});
      chk("lf_c", 8'h0e, {4'h0, lf4});
      chk("cp", 8'h12, {2'h0, cp});
      chk("trim", 8'h7b, trim);
      rd(dpc_pkg::OFS_LF_B, r);
      chk("lf_b_rd", 8'hc9, r);
   endtask : t_fixed_writes

   task automatic t_pll_start();
      logic [7:0] r;
      wr(dpc_pkg::OFS_VCO_DIV, 8'h02);
      wr(dpc_pkg::OFS_LOOP_COUNT, 8'h10);
      wr(dpc_pkg::OFS_REF_DIV, 8'h03);
      wr(dpc_pkg::OFS_PLL_CTRL, 8'h11);
      chk("cal_start", 8'h01, {7'h00, cal_start});
      for (int k = 0; k < 300 && locked !== 1'b1; k++) wclk(1);
      chk("cal_cmp", 8'h01, {7'h00, cal_cmp});
      chk("locked_src", 8'h03, {6'h00, locked, src});
      rd(dpc_pkg::OFS_STATUS, r);
      chk("status", 8'h22, r & 8'h22);
      wr(dpc_pkg::OFS_STATUS, 8'h00);
      rd(dpc_pkg::OFS_STATUS, r);
      chk("status_ro", 8'h22, r & 8'h22);
      rd(15'h0100, r);
      chk("unmapped", 8'h00, r);
      wr(dpc_pkg::OFS_PLL_CTRL, 8'h00);
      chk("off", 8'h00, {5'h00, en, locked, src});
      wr(dpc_pkg::OFS_PLL_CTRL, 8'h10);
      chk("direct", 8'h05, {5'h00, en, cal_start, cal_cmp});
      chk("src", 8'h00, {7'h00, src});
   endtask : t_pll_start

   // A reset after a completed calibration must re-arm the one-shot pump calibration.
   task automatic t_rearm();
      rst_in <= 1'b1;
      wclk(2);
      rst_in <= 1'b0;
      wclk(6);
      chk("rst_cal", 8'h00, {6'h00, en, cal_cmp});
      chk("rst_loop", 8'h08, loop_cnt);
      wr(dpc_pkg::OFS_PLL_CTRL, 8'h10);
      chk("recal", 8'h01, {7'h00, cal_start});
      for (int k = 0; k < 300 && cal_cmp !== 1'b1; k++) wclk(1);
      chk("recal_done", 8'h01, {6'h00, cal_start, cal_cmp});
   endtask : t_rearm

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   initial begin
      rst_in = 1'b1;
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
      err_total = 0;
      n_checks = 0;
      wclk(12);
      rst_in <= 1'b0;
      wclk(6);
      t_reset();
      t_ref_codes();
      t_vco_codes();
      t_loop_count();
      t_fixed_writes();
      t_pll_start();
      t_rearm();
      give_verdict();
   end

   // About forty frames of some 310 clocks each; the limit leaves ample room.
   initial begin
      wclk(40000);
      err_total++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
